// >>> hw/pcw_defines.vh
// Offsets, field positions, reset values and encodings of the PWM cycle configuration block
`ifndef PCW_DEFINES_VH
`define PCW_DEFINES_VH

`define PCW_CFG_ADDR        8'hd9
`define PCW_CFG_RESET       8'h00
`define PCW_BIT_RELOAD_SEL  7
`define PCW_BIT_OVF_IE      6
`define PCW_BIT_OVF_FLAG    5
`define PCW_CLSEL_HI        1
`define PCW_CLSEL_LO        0
`define PCW_CLSEL_8         2'h0
`define PCW_CLSEL_9         2'h1
`define PCW_CLSEL_10        2'h2
`define PCW_CLSEL_11        2'h3
`define PCW_CCAP_ADDR_BASE  8'he9
`define PCW_CCAP_ADDR_COUNT 12

`endif

// >>> hw/pcw_reload_bank.v
// Auto-reload register bank: one 16-bit word per channel, registered read data
`timescale 1ns/1ns
`default_nettype none
module pcw_reload_bank #(
   parameter CH   = 6,
   parameter AW   = 3
) (
   // Clock and reset
   input  wire          i_core_clk,
   input  wire          i_srst,
   // Byte write port
   input  wire          i_wr_en,
   input  wire          i_wr_high,
   input  wire [AW-1:0] i_wr_idx,
   input  wire [7:0]    i_wr_data,
   // Registered read port
   input  wire [AW-1:0] i_rd_idx,
   output reg  [15:0]   o_rd_data
);
   reg [15:0] mem [0:CH-1];
   integer k;

   always @(posedge i_core_clk) begin
      if (i_srst) begin
         for (k = 0; k < CH; k = k + 1) begin
            mem[k] <= 16'h0000;
         end
         o_rd_data <= 16'h0000;
      end else begin
         if (i_wr_en) begin
            if (i_wr_high) begin
               mem[i_wr_idx][15:8] <= i_wr_data;
            end else begin
               mem[i_wr_idx][7:0] <= i_wr_data;
            end
         end
         o_rd_data <= mem[i_rd_idx];
      end
   end
endmodule
`default_nettype wire

// >>> hw/pcw_cycle_config.v
// PWM cycle configuration register, reload bank steering and cycle overflow flag
`timescale 1ns/1ns
`default_nettype none
`include "pcw_defines.vh"
module pcw_cycle_config #(
   parameter CH = 6
) (
   // Clock and reset
   input  wire             i_core_clk,
   input  wire             i_srst,
   // Special-function register port
   input  wire [7:0]       i_sfr_addr,
   input  wire             i_sfr_wr,
   input  wire             i_sfr_rd,
   input  wire [7:0]       i_sfr_wdata,
   output reg  [7:0]       o_sfr_rdata,
   output reg              o_sfr_hit,
   // Main counter and channel modes
   input  wire [15:0]      i_array_main_counter,
   input  wire             i_count_tick,
   input  wire [CH-1:0]    i_pwm_mode,
   input  wire [CH-1:0]    i_wide_pwm_enable,
   // Compare register bank, owned outside
   output reg              o_ccap_wr,
   output reg  [7:0]       o_ccap_addr,
   output reg  [7:0]       o_ccap_wdata,
   input  wire [7:0]       i_ccap_rdata,
   // Per-channel results, then shared length select, overflow flag and interrupt
   output reg  [CH*16-1:0] o_reload_value,
   output reg  [CH-1:0]    o_reload_use,
   output reg  [CH*4-1:0]  o_channel_bits,
   output reg  [1:0]       o_cycle_length_select,
   output reg              o_cycle_overflow_flag,
   output reg              o_cycle_ovf_irq
);
   localparam AW = 3;

   reg        reload_bank_select_q;
   reg        cycle_ovf_irq_enable_q;
   reg        cycle_overflow_flag_q;
   reg [1:0]  cycle_length_select_q;
   reg [15:0] cnt_prev_q;
   reg        rd_bank_q;
   reg [7:0]  rd_addr_q;
   reg [AW-1:0] scan_q;
   reg [15:0] reload_shadow [0:CH-1];
   wire [15:0] bank_rdata;

   // Compare address layout: high byte then low byte per channel
   function ccap_hit;
      input [7:0] a;
      begin
         ccap_hit = (a >= `PCW_CCAP_ADDR_BASE) &&
                    (a < `PCW_CCAP_ADDR_BASE + `PCW_CCAP_ADDR_COUNT);
      end
   endfunction

   function [AW-1:0] ccap_idx;
      input [7:0] a;
      reg   [7:0] off;
      begin
         off = a - `PCW_CCAP_ADDR_BASE;
         ccap_idx = off[AW:1];
      end
   endfunction

   // Carry out of the bit picked by the length field
   function [3:0] sel_bit;
      input [1:0] s;
      begin
         case (s)
            `PCW_CLSEL_8:  sel_bit = 4'h7;
            `PCW_CLSEL_9:  sel_bit = 4'h8;
            `PCW_CLSEL_10: sel_bit = 4'h9;
            default:       sel_bit = 4'ha;
         endcase
      end
   endfunction

   wire cfg_wr  = i_sfr_wr && (i_sfr_addr == `PCW_CFG_ADDR);
   wire cc_wr   = i_sfr_wr && ccap_hit(i_sfr_addr);
   wire cfg_rd  = i_sfr_rd && (i_sfr_addr == `PCW_CFG_ADDR);
   wire rel_wr  = cc_wr && reload_bank_select_q;
   wire rel_rd  = i_sfr_rd && ccap_hit(i_sfr_addr) && reload_bank_select_q;
   wire [3:0] top_bit = sel_bit(cycle_length_select_q);
   // Overflow when the selected bit falls as the counter advances
   wire ovf_event = i_count_tick && cnt_prev_q[top_bit] &&
                    !i_array_main_counter[top_bit];

   pcw_reload_bank #(
      .CH (CH),
      .AW (AW)
   ) u_bank (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_wr_en    (rel_wr),
      .i_wr_high  (i_sfr_addr[0]),
      .i_wr_idx   (ccap_idx(i_sfr_addr)),
      .i_wr_data  (i_sfr_wdata),
      .i_rd_idx   (i_sfr_rd ? ccap_idx(i_sfr_addr) : scan_q),
      .o_rd_data  (bank_rdata)
   );

   always @(posedge i_core_clk) begin
      if (i_srst) begin
         reload_bank_select_q   <= 1'b0;
         cycle_ovf_irq_enable_q <= 1'b0;
         cycle_overflow_flag_q  <= 1'b0;
         cycle_length_select_q  <= `PCW_CLSEL_8;
         cnt_prev_q             <= 16'h0000;
      end else begin
         cnt_prev_q <= i_array_main_counter;
         if (cfg_wr) begin
            reload_bank_select_q   <= i_sfr_wdata[`PCW_BIT_RELOAD_SEL];
            cycle_ovf_irq_enable_q <= i_sfr_wdata[`PCW_BIT_OVF_IE];
            cycle_length_select_q  <= i_sfr_wdata[`PCW_CLSEL_HI:`PCW_CLSEL_LO];
         end
         // Set beats a clear written in the same cycle
         if (ovf_event) begin
            cycle_overflow_flag_q <= 1'b1;
         end else if (cfg_wr) begin
            cycle_overflow_flag_q <= i_sfr_wdata[`PCW_BIT_OVF_FLAG];
         end
      end
   end

   // Compare bank pass-through; writes go there only when bank 0 selected
   always @(posedge i_core_clk) begin
      if (i_srst) begin
         o_ccap_wr    <= 1'b0;
         o_ccap_addr  <= 8'h00;
         o_ccap_wdata <= 8'h00;
      end else begin
         o_ccap_wr    <= cc_wr && !reload_bank_select_q;
         o_ccap_addr  <= i_sfr_addr;
         o_ccap_wdata <= i_sfr_wdata;
      end
   end

   // Read data returns one cycle after the strobe
   always @(posedge i_core_clk) begin
      if (i_srst) begin
         rd_bank_q   <= 1'b0;
         rd_addr_q   <= 8'h00;
         o_sfr_hit   <= 1'b0;
         o_sfr_rdata <= 8'h00;
      end else begin
         rd_bank_q <= reload_bank_select_q;
         rd_addr_q <= i_sfr_addr;
         // Compare reads with bank 0 selected are answered outside this block
         o_sfr_hit <= cfg_rd || rel_rd;
         if (cfg_rd) begin
            o_sfr_rdata <= {reload_bank_select_q, cycle_ovf_irq_enable_q,
                            cycle_overflow_flag_q, 3'h0, cycle_length_select_q};
         end else if (rel_rd && i_sfr_addr[0]) begin
            o_sfr_rdata <= reload_shadow[ccap_idx(i_sfr_addr)][15:8];
         end else if (rel_rd) begin
            o_sfr_rdata <= reload_shadow[ccap_idx(i_sfr_addr)][7:0];
         end else begin
            o_sfr_rdata <= 8'h00;
         end
      end
   end

   // Reload bank scan keeps a copy for the channel outputs when CPU is idle
   reg scan_valid_q;
   reg [AW-1:0] scan_prev_q;
   always @(posedge i_core_clk) begin
      if (i_srst) begin
         scan_q       <= {AW{1'b0}};
         scan_prev_q  <= {AW{1'b0}};
         scan_valid_q <= 1'b0;
      end else begin
         // A word read in the cycle of a write is stale, so skip its copy
         scan_valid_q <= !i_sfr_rd && !rel_wr;
         scan_prev_q  <= scan_q;
         if (!i_sfr_rd) begin
            scan_q <= (scan_q == CH - 1) ? {AW{1'b0}} : scan_q + 3'h1;
         end
      end
   end

   integer n;
   always @(posedge i_core_clk) begin
      if (i_srst) begin
         for (n = 0; n < CH; n = n + 1) begin
            reload_shadow[n] <= 16'h0000;
         end
      end else begin
         if (scan_valid_q) begin
            reload_shadow[scan_prev_q] <= bank_rdata;
         end
         // Writes land in the copy at once so a read-back right after sees them
         if (rel_wr && i_sfr_addr[0]) begin
            reload_shadow[ccap_idx(i_sfr_addr)][15:8] <= i_sfr_wdata;
         end else if (rel_wr) begin
            reload_shadow[ccap_idx(i_sfr_addr)][7:0] <= i_sfr_wdata;
         end
      end
   end

   // Per-channel view of length and reload use
   integer c;
   always @(posedge i_core_clk) begin
      if (i_srst) begin
         o_reload_value        <= {CH*16{1'b0}};
         o_reload_use          <= {CH{1'b0}};
         o_channel_bits        <= {CH*4{1'b0}};
         o_cycle_length_select <= `PCW_CLSEL_8;
         o_cycle_overflow_flag <= 1'b0;
         o_cycle_ovf_irq       <= 1'b0;
      end else begin
         o_cycle_length_select <= cycle_length_select_q;
         o_cycle_overflow_flag <= cycle_overflow_flag_q;
         o_cycle_ovf_irq       <= cycle_overflow_flag_q && cycle_ovf_irq_enable_q;
         for (c = 0; c < CH; c = c + 1) begin
            o_reload_value[c*16 +: 16] <= reload_shadow[c];
            // Wide channels ignore the shared length
            if (i_wide_pwm_enable[c]) begin
               o_channel_bits[c*4 +: 4] <= 4'h0;
            end else begin
               o_channel_bits[c*4 +: 4] <= top_bit + 4'h1;
            end
            o_reload_use[c] <= i_pwm_mode[c] && !i_wide_pwm_enable[c] &&
                               (cycle_length_select_q != `PCW_CLSEL_8);
         end
      end
   end

   wire unused_ok = &{1'b0, i_ccap_rdata, rd_bank_q, rd_addr_q};
endmodule
`default_nettype wire

// >>> tb/pcw_cycle_config_props.sv
// Assertion checker for the PWM cycle configuration block
`timescale 1ns/1ns
`default_nettype none
`include "pcw_defines.vh"
module pcw_cycle_config_props #(parameter CH = 6) (
   // Clock and reset
   input wire logic            i_core_clk,
   input wire logic            i_srst,
   // Register port
   input wire logic            i_sfr_wr,
   input wire logic            i_sfr_rd,
   input wire logic [7:0]      i_sfr_addr,
   input wire logic [7:0]      i_sfr_wdata,
   input wire logic [7:0]      o_sfr_rdata,
   input wire logic            o_sfr_hit,
   // Counter and channel modes
   input wire logic            i_count_tick,
   input wire logic [15:0]     i_array_main_counter,
   input wire logic [CH-1:0]   i_pwm_mode,
   input wire logic [CH-1:0]   i_wide_pwm_enable,
   // Watched results
   input wire logic            o_ccap_wr,
   input wire logic [7:0]      o_ccap_addr,
   input wire logic [7:0]      o_ccap_wdata,
   input wire logic [CH-1:0]   o_reload_use,
   input wire logic [CH*4-1:0] o_channel_bits,
   input wire logic [1:0]      o_cycle_length_select,
   input wire logic            o_cycle_overflow_flag,
   input wire logic            o_cycle_ovf_irq
);
   wire       cw = i_sfr_wr && i_sfr_addr == `PCW_CFG_ADDR;
   wire [3:0] sb = 4'h7 + {2'h0, o_cycle_length_select};
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   sequence cfg_idle;
      cw ##1 !cw;
   endsequence
   // Length seen at the output lags the internal one, so recent writes are excluded
   sequence ovf_ev;
      i_count_tick && !i_array_main_counter[sb] && $past(i_array_main_counter[sb]) && !$past(cw) && !$past(cw, 2);
   endsequence
   a_len_write: assert property (cfg_idle |=> o_cycle_length_select == $past(i_sfr_wdata[1:0], 2))
      else $error("length select not taken");
   a_irq_enable: assert property ((cw && i_sfr_wdata[6:5] == 2'h3) ##1 !cw |=> o_cycle_ovf_irq)
      else $error("interrupt missing");
   a_flag_sticky: assert property ($fell(o_cycle_overflow_flag) |-> $past(cw && !i_sfr_wdata[5], 2))
      else $error("flag cleared without write");
   a_ovf_set: assert property (ovf_ev |-> ##2 o_cycle_overflow_flag)
      else $error("overflow not flagged");
   a_rd_zero: assert property (i_sfr_rd && i_sfr_addr == `PCW_CFG_ADDR |=> o_sfr_hit && o_sfr_rdata[4:2] == 3'h0)
      else $error("bad config read");
   a_ccap_fwd: assert property (o_ccap_wr |-> $past(i_sfr_wr && i_sfr_addr >= `PCW_CCAP_ADDR_BASE
      && i_sfr_addr <= 8'hf4) && o_ccap_addr == $past(i_sfr_addr) && o_ccap_wdata == $past(i_sfr_wdata))
      else $error("bad compare forward");
   a_wide_ignore: assert property (!$past(i_srst) && $past(i_pwm_mode[1] && i_wide_pwm_enable[1])
      |-> !o_reload_use[1] && o_channel_bits[7:4] == 4'h0) else $error("wide channel not ignored");
   a_len_apply: assert property (!$past(i_srst) && $past(i_pwm_mode[0] && !i_wide_pwm_enable[0])
      |-> o_channel_bits[3:0] == {2'h2, o_cycle_length_select} && o_reload_use[0] == (o_cycle_length_select != 2'h0))
      else $error("length not applied");
endmodule
bind pcw_cycle_config pcw_cycle_config_props #(.CH(CH)) u_props (
   .i_core_clk            (i_core_clk),
   .i_srst                (i_srst),
   .i_sfr_wr              (i_sfr_wr),
   .i_sfr_rd              (i_sfr_rd),
   .i_sfr_addr            (i_sfr_addr),
   .i_sfr_wdata           (i_sfr_wdata),
   .o_sfr_rdata           (o_sfr_rdata),
   .o_sfr_hit             (o_sfr_hit),
   .i_count_tick          (i_count_tick),
   .i_array_main_counter  (i_array_main_counter),
   .i_pwm_mode            (i_pwm_mode),
   .i_wide_pwm_enable     (i_wide_pwm_enable),
   .o_ccap_wr             (o_ccap_wr),
   .o_ccap_addr           (o_ccap_addr),
   .o_ccap_wdata          (o_ccap_wdata),
   .o_reload_use          (o_reload_use),
   .o_channel_bits        (o_channel_bits),
   .o_cycle_length_select (o_cycle_length_select),
   .o_cycle_overflow_flag (o_cycle_overflow_flag),
   .o_cycle_ovf_irq       (o_cycle_ovf_irq)
);
`default_nettype wire

// >>> tb/pcw_cycle_config_tb.sv
// Self-checking testbench for the PWM cycle configuration block
`timescale 1ns/1ns
`default_nettype none
`include "pcw_defines.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module pcw_cycle_config_tb;
   logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, tick = 1'b0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00;
   logic [15:0] cnt = 16'h0000;
   logic [5:0]  mode = 6'h03, wide = 6'h02;
   wire  [7:0]  rdata, ccap_addr, ccap_wdata;
   wire         hit, ccap_wr, flag, irq;
   wire  [1:0]  len;
   wire  [95:0] reload;
   wire  [5:0]  ruse;
   wire  [23:0] bits;
   int          n_errors = 0, tests_run = 0;
   always #5 clk = ~clk;
   pcw_cycle_config #(.CH(6)) dut (.i_core_clk(clk), .i_srst(srst), .i_sfr_addr(addr), .i_sfr_wr(wr),
      .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_array_main_counter(cnt),
      .i_count_tick(tick), .i_pwm_mode(mode), .i_wide_pwm_enable(wide), .o_ccap_wr(ccap_wr),
      .o_ccap_addr(ccap_addr), .o_ccap_wdata(ccap_wdata), .i_ccap_rdata(8'h00), .o_reload_value(reload),
      .o_reload_use(ruse), .o_channel_bits(bits), .o_cycle_length_select(len),
      .o_cycle_overflow_flag(flag), .o_cycle_ovf_irq(irq));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic h, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK("hit", h, hit)
      `CHK("rdata", e, rdata)
   endtask
   // Counter steps from hi to zero with tick high; clr adds a same-cycle clearing write
   task automatic ovf(input logic [15:0] hi, input logic clr);
      @(posedge clk);
      cnt <= hi;
      tick <= 1'b1;
      @(posedge clk);
      cnt <= 16'h0000;
      wdata <= 8'h00;
      addr <= `PCW_CFG_ADDR;
      wr <= clr;
      @(posedge clk);
      tick <= 1'b0;
      wr <= 1'b0;
      cyc(1);
   endtask
   task automatic t_len;
      rd_reg(`PCW_CFG_ADDR, 1'b1, `PCW_CFG_RESET);
      `CHK("rst", 16'h0000, reload[15:0])
      for (int c = 0; c < 4; c++) begin
         wr_reg(`PCW_CFG_ADDR, 8'h1c | 8'(c));
         cyc(1);
         `CHK("len", 2'(c), len)
         `CHK("bits0", 4'h8 + 4'(c), bits[3:0])
         `CHK("bits1", 4'h0, bits[7:4])
         `CHK("use", {5'h00, c != 0}, ruse)
         rd_reg(`PCW_CFG_ADDR, 1'b1, 8'(c));
      end
      $display("length test done");
   endtask
   task automatic t_ovf;
      for (int c = 0; c < 4; c++) begin
         wr_reg(`PCW_CFG_ADDR, 8'(c));
         ovf(16'h0100 << c, 1'b0);
         `CHK("no_ovf", 1'b0, flag)
         ovf(16'h0080 << c, 1'b0);
         `CHK("ovf", 1'b1, flag)
         `CHK("masked", 1'b0, irq)
         cyc(3);
         `CHK("sticky", 1'b1, flag)
         wr_reg(`PCW_CFG_ADDR, 8'(c));
         cyc(1);
         `CHK("clear", 1'b0, flag)
      end
      wr_reg(`PCW_CFG_ADDR, 8'h60);
      cyc(1);
      `CHK("irq", 2'h3, {flag, irq})
      wr_reg(`PCW_CFG_ADDR, 8'h00);
      ovf(16'h0080, 1'b1);
      `CHK("race", 1'b1, flag)
      $display("overflow test done");
   endtask
   task automatic t_bank;
      wr_reg(8'he9, 8'ha5);
      `CHK("fwd", 17'h1e9a5, {ccap_wr, ccap_addr, ccap_wdata})
      wr_reg(`PCW_CFG_ADDR, 8'h80);
      rd_reg(`PCW_CFG_ADDR, 1'b1, 8'h80);
      wr_reg(8'he9, 8'h5a);
      `CHK("steer", 1'b0, ccap_wr)
      wr_reg(8'hea, 8'hc3);
      rd_reg(8'hea, 1'b1, 8'hc3);
      rd_reg(8'he9, 1'b1, 8'h5a);
      cyc(20);
      `CHK("reload", 16'h5ac3, reload[15:0])
      wr_reg(`PCW_CFG_ADDR, 8'h00);
      rd_reg(8'he9, 1'b0, 8'h00);
      $display("bank test done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      cyc(1);
      t_len;
      t_ovf;
      t_bank;
      report_and_stop;
   end
   initial begin
      repeat (2000) @(posedge clk);
      n_errors++;
      report_and_stop;
   end
endmodule
`default_nettype wire
